// ===== logic/smi_mode_map.vh
// Overview of operation
// - Nothing depends on a running management clock; only its rising edges advance frames.
// - Every data-line bit is sampled by its receiver on the management clock rising edge.
// - A 4-bit bus address is latched from the address straps during reset.
// - Direct frames address one of 32 16-bit registers; one data field reads and writes.
// - Each frame opens with start code 01 after the idle high line.
// - On reads nobody drives turnaround bit one; the device drives zero, then data.
// - Mode register 0x0040..0x0043 select the RGMII copper, 1000X, 100FX and SGMII bridge modes.
// - Mode register 0x0044, 0x0045, 0x0046 select 1000M, 100M converters and SGMII-to-copper.
// - Writing 0x4000 to register 0x1F soft-resets and applies the selected mode.
// - In SGMII-to-RGMII bridge mode the device takes the RGMII MAC role.
// - Strapped media converter mode still answers management accesses.
// - 100M converter with pass-through: copper loss stops fiber transmit, fiber loss drops copper.
// - Extended registers are reached through access control and address/data with device select 11111.
// - Function field 00 address, 01 data, 10 increment always, 11 increment on writes.
`ifndef SMI_MODE_MAP_VH
`define SMI_MODE_MAP_VH

`define ADDR_BASIC_MODE_CONTROL 12'h000
`define ADDR_ABILITY_ADVERTISEMENT 12'h004
`define ADDR_GIGABIT_CONFIGURATION 12'h009
`define ADDR_MMD_ACCESS_CONTROL 12'h00D
`define ADDR_MMD_ADDRESS_DATA 12'h00E
`define ADDR_PORT_BEHAVIOUR_CONTROL 12'h010
`define ADDR_PIN_FUNCTION_SELECT 12'h018
`define ADDR_SOFT_RESET_CONTROL 12'h01F
`define ADDR_OPERATING_MODE_SELECT 12'h1DF
`define ADDR_FIBER_CONTROL 12'hC00
`define DIRECT_LIMIT 12'h020

`define RST_BASIC_MODE_CONTROL 16'h1140
`define RST_ABILITY_ADVERTISEMENT 16'h01E1
`define RST_GIGABIT_CONFIGURATION 16'h0300
`define RST_PORT_BEHAVIOUR_CONTROL 16'h5048
`define RST_PIN_FUNCTION_SELECT 16'h0000
`define RST_FIBER_CONTROL 16'h1140
`define RST_MMD_ACCESS_CONTROL 16'h0000
`define MODE_REG_BASE 13'h0008

`define SOFT_RESET_BIT 14
`define FUNC_HI 15
`define FUNC_LO 14
`define SELECT_HI 4

`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define MMD_DEVICE_SELECT 5'h1F
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA 2'h1
`define FUNC_INC_ALL 2'h2
`define FUNC_INC_WRITE 2'h3

`define MODE_RGMII_COPPER 3'h0
`define MODE_RGMII_1000X 3'h1
`define MODE_RGMII_100FX 3'h2
`define MODE_RGMII_SGMII 3'h3
`define MODE_CONV_1000M 3'h4
`define MODE_CONV_100M 3'h5
`define MODE_SGMII_COPPER 3'h6
`define MODE_SGMII_RGMII 3'h7

`define PIN_FUNC_RX_ERROR 4'hE
`define FRAME_FIELD_BITS 4'h4
`define FRAME_DATA_BITS 4'hF

`endif

// ===== logic/ext_store.v
`timescale 1ns/1ps
`default_nettype none
module ext_store
#(
    parameter AW = 12,
    parameter DW = 16
)
(
    input wire clk,
    input wire ce,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // No reset: contents are undefined until software writes them.
    always @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== logic/smi_mode_configuration.v
`timescale 1ns/1ps
`default_nettype none
`include "smi_mode_map.vh"
module smi_mode_configuration
#(
    parameter EXT_AW = 12
)
(
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe,
    input wire [3:0] address_straps,
    input wire [2:0] operating_mode_straps,
    input wire pass_through_strap,
    input wire copper_link_up,
    input wire fiber_link_up,
    input wire rx_error,
    output reg [2:0] active_mode,
    output reg mac_role,
    output reg prbs_permitted,
    output reg fiber_tx_enable,
    output reg copper_link_enable,
    output reg indicator_output_one
);
    localparam S_IDLE = 3'd0;
    localparam S_START = 3'd1;
    localparam S_OP = 3'd2;
    localparam S_PHY = 3'd3;
    localparam S_REG = 3'd4;
    localparam S_TA = 3'd5;
    localparam S_DATA = 3'd6;

    // Two-stage synchronisers for every pin from outside the clock domain.
    reg [7:0] pin_s1;
    reg [7:0] pin_s2;
    reg [2:0] mode_s1;
    reg [2:0] mode_s2;
    reg mdc_d;

    reg [3:0] phy_address;
    reg pass_through;
    reg [2:0] state;
    reg [3:0] cnt;
    reg [15:0] sh;
    reg [15:0] tx;
    reg [1:0] op;
    reg [4:0] regad;
    reg selected;
    reg wr_pulse;
    reg rd_done;
    reg [15:0] wr_data;

    reg [15:0] basic_mode_control;
    reg [15:0] ability_advertisement;
    reg [15:0] gigabit_configuration;
    reg [15:0] port_behaviour_control;
    reg [15:0] pin_function_select;
    reg [15:0] operating_mode_select;
    reg [15:0] fiber_control;
    reg [15:0] mmd_access_control;
    reg [15:0] mmd_address_data;
    reg soft_reset;

    wire mdc_now = pin_s2[0];
    wire mdio_now = pin_s2[1];
    wire copper_up = pin_s2[2];
    wire fiber_up = pin_s2[3];
    wire rx_err = pin_s2[4];
    wire mdc_rise = mdc_now & ~mdc_d;

    wire [1:0] func = mmd_access_control[`FUNC_HI:`FUNC_LO];
    wire mmd_ok = mmd_access_control[`SELECT_HI:0] == `MMD_DEVICE_SELECT;
    wire at_addr_data = {7'h00, regad} == `ADDR_MMD_ADDRESS_DATA;
    wire indirect = at_addr_data && (func != `FUNC_ADDRESS);
    wire [11:0] ext_addr = mmd_address_data[EXT_AW-1:0];
    wire [11:0] tgt = indirect ? ext_addr : {7'h00, regad};
    // Indirect access to the access registers themselves, or with a wrong select, is ignored.
    wire ignored = indirect && (!mmd_ok || ext_addr == `ADDR_MMD_ACCESS_CONTROL
                   || ext_addr == `ADDR_MMD_ADDRESS_DATA);
    wire load_addr = at_addr_data && !indirect && mmd_ok;
    wire is_read = op == `OP_READ;
    wire [15:0] mem_rdata;
    wire mem_we;
    reg [15:0] rd_value;

    function in_store;
        input [11:0] a;
        begin
            in_store = (a >= `DIRECT_LIMIT) && (a != `ADDR_OPERATING_MODE_SELECT)
                       && (a != `ADDR_FIBER_CONTROL);
        end
    endfunction

    function is_bridge;
        input [2:0] m;
        begin
            is_bridge = (m == `MODE_RGMII_SGMII) || (m == `MODE_SGMII_RGMII);
        end
    endfunction

    assign mem_we = wr_pulse && !ignored && in_store(tgt);

    ext_store #(
        .AW(EXT_AW),
        .DW(16)
    ) u_store (
        .clk(clk),
        .ce(ce),
        .we(mem_we),
        .waddr(tgt[EXT_AW-1:0]),
        .wdata(wr_data),
        .raddr(tgt[EXT_AW-1:0]),
        .rdata(mem_rdata)
    );

    always @(posedge clk)
    begin
        if (ce)
        begin
            pin_s1 <= {3'h0, rx_error, fiber_link_up, copper_link_up, mdio_in, mdc};
            pin_s2 <= pin_s1;
            mode_s1 <= operating_mode_straps;
            mode_s2 <= mode_s1;
            pin_s1[7:5] <= address_straps[2:0];
            pin_s2[7:5] <= pin_s1[7:5];
        end
    end

    reg addr3_s1;
    reg addr3_s2;
    reg llpt_s1;
    reg llpt_s2;

    always @(posedge clk)
    begin
        if (ce)
        begin
            addr3_s1 <= address_straps[3];
            addr3_s2 <= addr3_s1;
            llpt_s1 <= pass_through_strap;
            llpt_s2 <= llpt_s1;
        end
    end

    always @*
    begin
        rd_value = 16'h0000;
        if (ignored)
            rd_value = 16'h0000;
        else if (tgt == `ADDR_BASIC_MODE_CONTROL)
            rd_value = basic_mode_control;
        else if (tgt == `ADDR_ABILITY_ADVERTISEMENT)
            rd_value = ability_advertisement;
        else if (tgt == `ADDR_GIGABIT_CONFIGURATION)
            rd_value = gigabit_configuration;
        else if (tgt == `ADDR_MMD_ACCESS_CONTROL)
            rd_value = mmd_access_control;
        else if (tgt == `ADDR_MMD_ADDRESS_DATA)
            rd_value = mmd_address_data;
        else if (tgt == `ADDR_PORT_BEHAVIOUR_CONTROL)
            rd_value = port_behaviour_control;
        else if (tgt == `ADDR_PIN_FUNCTION_SELECT)
            rd_value = pin_function_select;
        else if (tgt == `ADDR_OPERATING_MODE_SELECT)
            rd_value = operating_mode_select;
        else if (tgt == `ADDR_FIBER_CONTROL)
            rd_value = fiber_control;
        else if (in_store(tgt))
            rd_value = mem_rdata;
    end

    // Frame engine: advances only on sampled management clock rising edges.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            mdc_d <= 1'b0;
            state <= S_IDLE;
            cnt <= 4'h0;
            sh <= 16'h0000;
            tx <= 16'h0000;
            op <= 2'h0;
            regad <= 5'h00;
            selected <= 1'b0;
            wr_pulse <= 1'b0;
            rd_done <= 1'b0;
            wr_data <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe <= 1'b0;
        end
        else if (ce)
        begin
            mdc_d <= mdc_now;
            wr_pulse <= 1'b0;
            rd_done <= 1'b0;
            if (mdc_rise)
            begin
                sh <= {sh[14:0], mdio_now};
                case (state)
                    S_IDLE:
                    begin
                        if (!mdio_now)
                            state <= S_START;
                    end
                    S_START:
                    begin
                        cnt <= 4'h1;
                        state <= mdio_now ? S_OP : S_IDLE;
                    end
                    S_OP:
                    begin
                        if (cnt == 4'h0)
                        begin
                            op <= {sh[0], mdio_now};
                            cnt <= `FRAME_FIELD_BITS;
                            state <= S_PHY;
                        end
                        else
                            cnt <= cnt - 4'h1;
                    end
                    S_PHY:
                    begin
                        if (cnt == 4'h0)
                        begin
                            selected <= ({sh[3:0], mdio_now} == {1'b0, phy_address})
                                        && (op == `OP_READ || op == `OP_WRITE);
                            cnt <= `FRAME_FIELD_BITS;
                            state <= S_REG;
                        end
                        else
                            cnt <= cnt - 4'h1;
                    end
                    S_REG:
                    begin
                        if (cnt == 4'h0)
                        begin
                            regad <= {sh[3:0], mdio_now};
                            cnt <= 4'h1;
                            state <= S_TA;
                        end
                        else
                            cnt <= cnt - 4'h1;
                    end
                    S_TA:
                    begin
                        if (cnt == 4'h1)
                        begin
                            // First turnaround bit was left to the pull-up; drive zero next.
                            mdio_oe <= selected && is_read;
                            mdio_out <= 1'b0;
                            cnt <= 4'h0;
                        end
                        else
                        begin
                            tx <= {rd_value[14:0], 1'b0};
                            mdio_out <= rd_value[15];
                            rd_done <= selected && is_read;
                            cnt <= `FRAME_DATA_BITS;
                            state <= S_DATA;
                        end
                    end
                    S_DATA:
                    begin
                        tx <= {tx[14:0], 1'b0};
                        mdio_out <= tx[15];
                        if (cnt == 4'h0)
                        begin
                            mdio_oe <= 1'b0;
                            mdio_out <= 1'b1;
                            wr_data <= {sh[14:0], mdio_now};
                            wr_pulse <= selected && (op == `OP_WRITE);
                            state <= S_IDLE;
                        end
                        else
                            cnt <= cnt - 4'h1;
                    end
                    default:
                    begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Register file. Straps are caught while reset is held, after synchronisation.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            if (ce)
            begin
                phy_address <= {addr3_s2, pin_s2[7:5]};
                pass_through <= llpt_s2;
                operating_mode_select <= {`MODE_REG_BASE, mode_s2};
                active_mode <= mode_s2;
            end
            basic_mode_control <= `RST_BASIC_MODE_CONTROL;
            ability_advertisement <= `RST_ABILITY_ADVERTISEMENT;
            gigabit_configuration <= `RST_GIGABIT_CONFIGURATION;
            port_behaviour_control <= `RST_PORT_BEHAVIOUR_CONTROL;
            pin_function_select <= `RST_PIN_FUNCTION_SELECT;
            fiber_control <= `RST_FIBER_CONTROL;
            mmd_access_control <= `RST_MMD_ACCESS_CONTROL;
            mmd_address_data <= 16'h0000;
            soft_reset <= 1'b0;
        end
        else if (ce)
        begin
            soft_reset <= 1'b0;
            // Applying the mode only on soft reset lets software finish its setup writes first.
            if (soft_reset)
                active_mode <= operating_mode_select[2:0];
            if (rd_done && indirect && !ignored && func == `FUNC_INC_ALL)
                mmd_address_data <= mmd_address_data + 16'h0001;
            if (wr_pulse && load_addr)
                mmd_address_data <= wr_data;
            else if (wr_pulse && !ignored)
            begin
                if (indirect && (func == `FUNC_INC_ALL || func == `FUNC_INC_WRITE))
                    mmd_address_data <= mmd_address_data + 16'h0001;
                if (tgt == `ADDR_BASIC_MODE_CONTROL)
                    basic_mode_control <= wr_data;
                else if (tgt == `ADDR_ABILITY_ADVERTISEMENT)
                    ability_advertisement <= wr_data;
                else if (tgt == `ADDR_GIGABIT_CONFIGURATION)
                    gigabit_configuration <= wr_data;
                else if (tgt == `ADDR_MMD_ACCESS_CONTROL)
                    mmd_access_control <= wr_data;
                else if (tgt == `ADDR_PORT_BEHAVIOUR_CONTROL)
                    port_behaviour_control <= wr_data;
                else if (tgt == `ADDR_PIN_FUNCTION_SELECT)
                    pin_function_select <= wr_data;
                else if (tgt == `ADDR_SOFT_RESET_CONTROL)
                    soft_reset <= wr_data[`SOFT_RESET_BIT];
                else if (tgt == `ADDR_OPERATING_MODE_SELECT)
                    operating_mode_select <= wr_data;
                else if (tgt == `ADDR_FIBER_CONTROL)
                    fiber_control <= wr_data;
            end
        end
    end

    // Mode-dependent outputs, and the indicator output chosen by the pin function select.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            mac_role <= 1'b0;
            prbs_permitted <= 1'b0;
            fiber_tx_enable <= 1'b0;
            copper_link_enable <= 1'b0;
            indicator_output_one <= 1'b0;
        end
        else if (ce)
        begin
            mac_role <= active_mode == `MODE_SGMII_RGMII;
            prbs_permitted <= !is_bridge(active_mode);
            if (active_mode == `MODE_CONV_100M && pass_through)
            begin
                fiber_tx_enable <= copper_up;
                copper_link_enable <= fiber_up;
            end
            else
            begin
                fiber_tx_enable <= 1'b1;
                copper_link_enable <= 1'b1;
            end
            if (pin_function_select[3:0] == `PIN_FUNC_RX_ERROR)
                indicator_output_one <= rx_err;
            else
                indicator_output_one <= copper_up;
        end
    end
endmodule
`default_nettype wire

// ===== tb/smi_mode_configuration_chk.sv
`timescale 1ns/1ps
`default_nettype none
module smi_mode_configuration_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic pass_through_strap,
    input wire logic copper_link_up,
    input wire logic fiber_link_up,
    input wire logic [2:0] active_mode,
    input wire logic mac_role,
    input wire logic fiber_tx_enable,
    input wire logic copper_link_enable
);
    logic mdc_q = 1'h0;
    logic mdc_q2 = 1'h0;
    logic [3:0] since_rise = 4'hF;
    logic [4:0] oe_rises = 5'h00;
    wire mdc_rise = mdc_q && !mdc_q2;

    // Cycles since the last management clock rise, saturating so a stopped clock reads as idle.
    always @(posedge clk)
    begin
        mdc_q <= mdc;
        mdc_q2 <= mdc_q;
        if (sys_rst)
            since_rise <= 4'hF;
        else if (mdc_rise)
            since_rise <= 4'h0;
        else if (since_rise != 4'hF)
            since_rise <= since_rise + 4'h1;
        if (sys_rst || !mdio_oe)
            oe_rises <= 5'h00;
        else if (mdc_rise)
            oe_rises <= oe_rises + 5'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    quiet_reset_a: assert property ($fell(sys_rst) |-> !mdio_oe && mdio_out)
        else $error("line driven at reset release");
    oe_timing_a: assert property ($changed(mdio_oe) |-> since_rise inside {[0:6]})
        else $error("enable moved without a clock rise");
    out_timing_a: assert property ($changed(mdio_out) |-> since_rise inside {[0:6]})
        else $error("data moved without a clock rise");
    no_hold_a: assert property (mdio_oe |-> since_rise < 4'h8)
        else $error("line held while clock stands");
    ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out [*6])
        else $error("second turnaround bit not zero");
    read_length_a: assert property ($fell(mdio_oe) |-> mdio_out && oe_rises == 5'h11)
        else $error("read drive length wrong");
    bridge_role_a: assert property (!$past(sys_rst) |-> mac_role == ($past(active_mode) == 3'h7))
        else $error("mac role does not match mode");
    mode_apply_a: assert property (!$past(sys_rst, 2) && $changed(active_mode) |-> since_rise inside {[0:8]})
        else $error("mode changed outside a frame");
    pass_off_a: assert property (active_mode != 3'h5 && $past(active_mode) != 3'h5 && !$past(sys_rst)
        |-> fiber_tx_enable && copper_link_enable)
        else $error("link gated outside converter mode");
    copper_loss_a: assert property ($fell(copper_link_up) && active_mode == 3'h5 && pass_through_strap
        |-> ##[1:6] !fiber_tx_enable)
        else $error("fiber kept on after copper loss");
    fiber_loss_a: assert property ($fell(fiber_link_up) && active_mode == 3'h5 && pass_through_strap
        |-> ##[1:6] !copper_link_enable)
        else $error("copper kept on after fiber loss");
endmodule

bind smi_mode_configuration smi_mode_configuration_chk chk (
    .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .pass_through_strap(pass_through_strap), .copper_link_up(copper_link_up), .fiber_link_up(fiber_link_up),
    .active_mode(active_mode), .mac_role(mac_role), .fiber_tx_enable(fiber_tx_enable),
    .copper_link_enable(copper_link_enable)
);
`default_nettype wire

// ===== tb/station_model.sv
`timescale 1ns/1ps
`default_nettype none
module station_model (
    input wire logic clk,
    input wire logic mdio_line,
    output logic mdc,
    output logic sta_out,
    output logic sta_oe
);
    // The clock stands low between frames; a released line floats high on the pull-up.
    initial
    begin
        mdc = 1'h0;
        sta_out = 1'h1;
        sta_oe = 1'h0;
    end

    // Data changes with the falling clock and is taken at the rise, an 80 ns bit time.
    task automatic clock_bit(input logic drive, input logic val, output logic seen);
        mdc <= 1'h0;
        sta_oe <= drive;
        sta_out <= val;
        repeat (4) @(posedge clk);
        mdc <= 1'h1;
        seen = mdio_line;
        repeat (4) @(posedge clk);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta_ok);
        logic [31:0] w;
        logic s;
        logic t1;
        w = {2'h1, op, phy, ra, 2'h2, wd};
        t1 = 1'h0;
        ta_ok = 1'h0;
        rd = 16'h0000;
        for (int i = 31; i >= 0; i--)
        begin
            clock_bit(op != 2'h2 || i > 17, w[i], s);
            if (i == 17)
                t1 = s;
            if (i == 16)
                ta_ok = t1 && !s;
            if (i < 16)
                rd[i] = s;
        end
        mdc <= 1'h0;
        sta_oe <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/smi_mode_configuration_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module smi_mode_configuration_test;
    typedef struct packed { logic [11:0] xa; logic [15:0] xv; logic [2:0] m; logic mac; } row_t;
    typedef struct packed { logic [1:0] op; logic [4:0] r; logic [15:0] v; } step_t;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic ce = 1'h1;
    logic [3:0] address_straps = 4'h5;
    logic [2:0] operating_mode_straps = 3'h5;
    logic pass_through_strap = 1'h1;
    logic copper_link_up = 1'h1;
    logic fiber_link_up = 1'h1;
    logic rx_error = 1'h0;
    logic mdc, sta_out, sta_oe, mdio_out, mdio_oe, mac_role, prbs_permitted;
    logic fiber_tx_enable, copper_link_enable, indicator_output_one, ta;
    logic [2:0] active_mode, prev;
    logic [4:0] phy = 5'h05;
    logic [15:0] rd;
    int failures = 0;
    int n_tests = 0;
    wire mdio_line = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'h1);
    row_t rows [8] = '{'{12'h000, 16'h1140, 3'h0, 1'h0}, '{12'hC00, 16'h1140, 3'h1, 1'h0},
        '{12'hC00, 16'h2100, 3'h2, 1'h0}, '{12'hC00, 16'h1140, 3'h3, 1'h0},
        '{12'hC00, 16'h1140, 3'h4, 1'h0}, '{12'h018, 16'h000E, 3'h5, 1'h0},
        '{12'h009, 16'h0B00, 3'h6, 1'h0}, '{12'h004, 16'h01E1, 3'h7, 1'h1}};
    step_t steps [26] = '{'{2'h1, 5'h0D, 16'h001F}, '{2'h1, 5'h0E, 16'h0170}, '{2'h1, 5'h0D, 16'h801F},
        '{2'h1, 5'h0E, 16'h0C51}, '{2'h1, 5'h0E, 16'h0C52}, '{2'h1, 5'h0D, 16'h001F},
        '{2'h1, 5'h0E, 16'h0170}, '{2'h1, 5'h0D, 16'h801F}, '{2'h2, 5'h0E, 16'h0C51},
        '{2'h2, 5'h0E, 16'h0C52}, '{2'h1, 5'h0D, 16'h001F}, '{2'h1, 5'h0E, 16'h0171},
        '{2'h1, 5'h0D, 16'hC01F}, '{2'h2, 5'h0E, 16'h0C52}, '{2'h2, 5'h0E, 16'h0C52},
        '{2'h1, 5'h0E, 16'h0C53}, '{2'h1, 5'h0D, 16'h001F}, '{2'h1, 5'h0E, 16'h0171},
        '{2'h1, 5'h0D, 16'h401F}, '{2'h2, 5'h0E, 16'h0C53}, '{2'h2, 5'h0E, 16'h0C53},
        '{2'h1, 5'h0D, 16'h401E}, '{2'h1, 5'h0E, 16'h1234}, '{2'h2, 5'h0E, 16'h0000},
        '{2'h1, 5'h0D, 16'h401F}, '{2'h2, 5'h0E, 16'h0C53}};

    always #5 clk = ~clk;

    smi_mode_configuration dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .address_straps(address_straps), .operating_mode_straps(operating_mode_straps),
        .pass_through_strap(pass_through_strap), .copper_link_up(copper_link_up), .fiber_link_up(fiber_link_up),
        .rx_error(rx_error), .active_mode(active_mode), .mac_role(mac_role), .prbs_permitted(prbs_permitted),
        .fiber_tx_enable(fiber_tx_enable), .copper_link_enable(copper_link_enable),
        .indicator_output_one(indicator_output_one)
    );
    station_model sta (.clk(clk), .mdio_line(mdio_line), .mdc(mdc), .sta_out(sta_out), .sta_oe(sta_oe));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic fr(input logic [1:0] op, input logic [4:0] r, input logic [15:0] v);
        sta.frame(op, phy, r, v, rd, ta);
        if (op == 2'h2)
            `CHECK(ta, 1'h1)
    endtask

    // Registers above 1Fh go through the indirect pair with the only valid device select.
    task automatic acc(input logic [1:0] op, input logic [11:0] a, input logic [15:0] v);
        if (a > 12'h01F)
        begin
            fr(2'h1, 5'h0D, 16'h001F);
            fr(2'h1, 5'h0E, {4'h0, a});
            fr(2'h1, 5'h0D, 16'h401F);
        end
        fr(op, a > 12'h01F ? 5'h0E : a[4:0], v);
    endtask

    // The straps settle through synchronisers, so reset is held well past their latency.
    task automatic do_reset();
        sys_rst <= 1'h1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (16) @(posedge clk);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial
    begin
        do_reset();
        acc(2'h2, 12'h000, 16'h0000);
        `CHECK(rd, 16'h1140)
        acc(2'h2, 12'h1DF, 16'h0000);
        `CHECK(rd, 16'h0045)
        sta.frame(2'h1, 5'h06, 5'h18, 16'h1234, rd, ta);
        sta.frame(2'h0, phy, 5'h18, 16'h1234, rd, ta);
        sta.frame(2'h3, phy, 5'h18, 16'h1234, rd, ta);
        sta.frame(2'h2, 5'h06, 5'h00, 16'h0000, rd, ta);
        `CHECK({ta, rd}, 17'h0FFFF)
        acc(2'h2, 12'h018, 16'h0000);
        `CHECK(rd, 16'h0000)
        $display("test address_filter done");
        copper_link_up <= 1'h0;
        repeat (6) @(posedge clk);
        `CHECK({fiber_tx_enable, copper_link_enable, indicator_output_one}, 3'h2)
        copper_link_up <= 1'h1;
        fiber_link_up <= 1'h0;
        repeat (6) @(posedge clk);
        `CHECK({fiber_tx_enable, copper_link_enable, indicator_output_one}, 3'h5)
        fiber_link_up <= 1'h1;
        $display("test pass_through done");
        foreach (rows[i])
        begin
            prev = active_mode;
            acc(2'h1, 12'h1DF, {13'h0008, rows[i].m});
            acc(2'h1, rows[i].xa, rows[i].xv);
            `CHECK(active_mode, prev)
            fr(2'h1, 5'h1F, 16'h4000);
            `CHECK({active_mode, mac_role}, {rows[i].m, rows[i].mac})
            `CHECK(prbs_permitted, rows[i].m != 3'h3 && rows[i].m != 3'h7)
            acc(2'h2, rows[i].xa, 16'h0000);
            `CHECK(rd, rows[i].xv)
        end
        $display("test mode_table done");
        rx_error <= 1'h1;
        copper_link_up <= 1'h0;
        repeat (6) @(posedge clk);
        `CHECK(indicator_output_one, 1'h1)
        rx_error <= 1'h0;
        repeat (6) @(posedge clk);
        `CHECK(indicator_output_one, 1'h0)
        copper_link_up <= 1'h1;
        $display("test indicator_route done");
        foreach (steps[i])
        begin
            fr(steps[i].op, steps[i].r, steps[i].v);
            if (steps[i].op == 2'h2)
                `CHECK(rd, steps[i].v)
        end
        $display("test indirect_access done");
        address_straps <= 4'hA;
        operating_mode_straps <= 3'h7;
        do_reset();
        phy = 5'h0A;
        acc(2'h2, 12'h1DF, 16'h0000);
        `CHECK({rd, active_mode, mac_role}, 20'h0047F)
        acc(2'h2, 12'h018, 16'h0000);
        `CHECK(rd, 16'h0000)
        sta.frame(2'h2, 5'h05, 5'h00, 16'h0000, rd, ta);
        `CHECK(rd, 16'hFFFF)
        $display("test second_reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
